// *** src/lpmtc_consts.svh ***
/*
 Timing and bit rate constants for the LIN channel mode and timing control.
 Assumes a 20 MHz system clock (50 ns period); counts are derived from it.
*/
`ifndef LPMTC_CONSTS_SVH
`define LPMTC_CONSTS_SVH

`define LPMTC_CLK_NS 50
// Times in ns as printed, counts derived
`define LPMTC_T_TXDOM_MIN_NS 3750000
`define LPMTC_TXDOM_CYC ((`LPMTC_T_TXDOM_MIN_NS + `LPMTC_CLK_NS - 1) / `LPMTC_CLK_NS)
`define LPMTC_T_FIRSTDOM_MAX_NS 80000000
`define LPMTC_FIRSTDOM_CYC (`LPMTC_T_FIRSTDOM_MAX_NS / `LPMTC_CLK_NS)
`define LPMTC_T_TOGGLE_MAX_NS 45000
`define LPMTC_TOGGLE_CYC (`LPMTC_T_TOGGLE_MAX_NS / `LPMTC_CLK_NS)
`define LPMTC_T_CONFIRM_MIN_NS 1875
`define LPMTC_CONFIRM_CYC ((`LPMTC_T_CONFIRM_MIN_NS + `LPMTC_CLK_NS - 1) / `LPMTC_CLK_NS)
`define LPMTC_T_SLEEP_MIN_NS 50000
`define LPMTC_SLEEP_CYC ((`LPMTC_T_SLEEP_MIN_NS + `LPMTC_CLK_NS - 1) / `LPMTC_CLK_NS)
`define LPMTC_T_BUSWU_MIN_NS 40000
`define LPMTC_BUSWU_CYC ((`LPMTC_T_BUSWU_MIN_NS + `LPMTC_CLK_NS - 1) / `LPMTC_CLK_NS)
`define LPMTC_T_ENWU_MAX_NS 15000
`define LPMTC_ENWU_CYC (`LPMTC_T_ENWU_MAX_NS / `LPMTC_CLK_NS)
`define LPMTC_T_WAKEWU_MIN_NS 10000
`define LPMTC_WAKEWU_CYC ((`LPMTC_T_WAKEWU_MIN_NS + `LPMTC_CLK_NS - 1) / `LPMTC_CLK_NS)
// Bit rates in bit/s
`define LPMTC_RATE_NORMAL 20000
`define LPMTC_RATE_SLOW 10000
`define LPMTC_RATE_FAST 100000
`define LPMTC_CNT_W 21

`endif

// *** src/lpmtc_pkg.sv ***
/*
 Types for the LIN channel mode and timing control.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package lpmtc_pkg;
	typedef enum logic [1:0]
	{
		LPMTC_SLEEP = 2'b00,
		LPMTC_NORMAL = 2'b01,
		LPMTC_GO_SLEEP = 2'b10
	} lpmtc_mode_type;
	typedef enum logic [1:0]
	{
		LPMTC_RATE_NORM = 2'b00,
		LPMTC_RATE_SLOWV = 2'b01,
		LPMTC_RATE_FASTM = 2'b10
	} lpmtc_rate_type;
endpackage

// *** src/lpmtc_filter.sv ***
/*
 Deglitch filter: output takes the input level after it held for LEN cycles.
 Assumes inputs synchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module lpmtc_filter #(
	parameter int unsigned LEN = 800
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic init_in,
	input wire logic level_in,
	output logic level_out
);
	logic [20:0] cnt_q;

	// Count while input differs from output; restart on any bounce
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cnt_q <= 21'h0;
			level_out <= init_in; // Start from the idle level given by the parent
		end
		else if (level_in == level_out)
			cnt_q <= 21'h0;
		else if (cnt_q >= 21'(LEN - 1))
		begin
			cnt_q <= 21'h0;
			level_out <= level_in;
		end
		else
			cnt_q <= cnt_q + 21'h1;
	end
endmodule
`default_nettype wire

// *** src/lpmtc_top.sv ***
/*
 Mode and timing control of one LIN physical-layer channel: sleep, wake,
 dominant timeout, first-dominant validation, fast-rate toggle, undervoltage.
 Assumes all inputs synchronous to the 20 MHz clk_in; analog parts outside.
*/
// Function
// - Release bus after transmit held dominant too long
// - Validate first dominant within 80 ms
// - Confirm fast rate by receive low pulse
// - Mode fall enters sleep, regulator off later
// - Bus wake needs 40-100 us deglitch
// - Mode high turns regulator on within 15us
// - Wake pin change wakes after deglitch
// - Undervoltage disables transmit path
// - Bus inactive outside Normal mode
// - Normal or slow rate per variant
// - Fast mode supports up to 100 kbit/s
// - Overtemperature forces recessive, regulator off
`timescale 1ns/100ps
`default_nettype none
`include "lpmtc_consts.svh"
module lpmtc_top #(
	parameter int unsigned TXDOM_CYC = `LPMTC_TXDOM_CYC,
	parameter int unsigned FIRSTDOM_CYC = `LPMTC_FIRSTDOM_CYC,
	parameter bit SLOW_VARIANT = 1'b0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic tx_data_in,
	input wire logic mode_ctrl_in,
	input wire logic wake_in,
	input wire logic bus_level_in,
	input wire logic supply_pin_low_in,
	input wire logic over_temp_in,
	output logic bus_drive_dom_out,
	output logic rx_data_out,
	output logic regulator_switch_output,
	output lpmtc_pkg::lpmtc_mode_type mode_out,
	output lpmtc_pkg::lpmtc_rate_type rate_out
);
	import lpmtc_pkg::*;

	lpmtc_mode_type mode_q;
	logic mode_ctrl_q, wake_filt, wake_filt_q, bus_dom_filt;
	logic [21:0] txdom_cnt_q;
	logic [20:0] first_cnt_q;
	logic [11:0] sleep_cnt_q;
	logic [11:0] tog_cnt_q;
	logic [7:0] conf_cnt_q;
	logic tx_valid_q, fast_q, tog_armed_q, tog_tx_seen_q, tx_timeout_q;
	logic en_rise, en_fall, wake_evt;

	// ****************************************
	// Edge detection and deglitch filters
	// ****************************************
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			mode_ctrl_q <= 1'b0;
			wake_filt_q <= 1'b0;
		end
		else
		begin
			mode_ctrl_q <= mode_ctrl_in;
			wake_filt_q <= wake_filt;
		end
	end
	assign en_rise = mode_ctrl_in && !mode_ctrl_q;
	assign en_fall = !mode_ctrl_in && mode_ctrl_q;
	assign wake_evt = wake_filt != wake_filt_q;

	lpmtc_filter #(.LEN(`LPMTC_WAKEWU_CYC)) u_wake_filt (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.init_in(1'b0),
		.level_in(wake_in),
		.level_out(wake_filt)
	);
	lpmtc_filter #(.LEN(`LPMTC_BUSWU_CYC)) u_bus_filt (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.init_in(1'b0),
		.level_in(!bus_level_in && mode_q == LPMTC_SLEEP),
		.level_out(bus_dom_filt)
	);

	// ****************************************
	// Mode state machine
	// ****************************************
	// Mode rising edge wakes in one cycle, well inside 15 us
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			mode_q <= LPMTC_SLEEP;
			sleep_cnt_q <= 12'h0;
		end
		else
		begin
			case (mode_q)
				LPMTC_NORMAL:
				begin
					sleep_cnt_q <= 12'h0;
					if (en_fall)
						mode_q <= LPMTC_GO_SLEEP;
				end
				LPMTC_GO_SLEEP:
				begin
					// A short low pulse is the toggle, not a sleep request
					if (en_rise)
						mode_q <= LPMTC_NORMAL;
					else if (sleep_cnt_q >= 12'(`LPMTC_SLEEP_CYC - 1))
						mode_q <= LPMTC_SLEEP;
					else
						sleep_cnt_q <= sleep_cnt_q + 12'h1;
				end
				LPMTC_SLEEP:
				begin
					sleep_cnt_q <= 12'h0;
					if (en_rise || mode_ctrl_in || bus_dom_filt || wake_evt)
						mode_q <= LPMTC_NORMAL;
				end
				default:
					mode_q <= LPMTC_SLEEP;
			endcase
		end
	end

	// ****************************************
	// Transmit dominant timeout
	// ****************************************
	// Receiver stays active; only the driver is released
	always_ff @(posedge clk_in)
	begin
		if (rst_in || tx_data_in || mode_q != LPMTC_NORMAL)
		begin
			txdom_cnt_q <= 22'h0;
			tx_timeout_q <= 1'b0;
		end
		else if (txdom_cnt_q >= 22'(TXDOM_CYC - 1))
			tx_timeout_q <= 1'b1;
		else
			txdom_cnt_q <= txdom_cnt_q + 22'h1;
	end

	// ****************************************
	// First dominant validation
	// ****************************************
	// Transmit path valid once TX recessive seen, or at latest after 80 ms
	always_ff @(posedge clk_in)
	begin
		if (rst_in || mode_q != LPMTC_NORMAL)
		begin
			first_cnt_q <= 21'h0;
			tx_valid_q <= 1'b0;
		end
		else if (tx_data_in || first_cnt_q >= 21'(FIRSTDOM_CYC - 1))
			tx_valid_q <= 1'b1;
		else
			first_cnt_q <= first_cnt_q + 21'h1;
	end

	// ****************************************
	// Fast baud rate toggle
	// ****************************************
	// Host timing is assumed; only the 45 us pulse limit and the TX low-then-high sequence are checked
	always_ff @(posedge clk_in)
	begin
		if (rst_in || mode_q == LPMTC_SLEEP)
		begin
			tog_armed_q <= 1'b0;
			tog_tx_seen_q <= 1'b0;
			tog_cnt_q <= 12'h0;
			fast_q <= 1'b0;
			conf_cnt_q <= 8'h0;
		end
		else
		begin
			if (conf_cnt_q != 8'h0)
				conf_cnt_q <= conf_cnt_q - 8'h1;
			if (en_fall)
			begin
				tog_armed_q <= 1'b1;
				tog_tx_seen_q <= 1'b0;
				tog_cnt_q <= 12'h0;
			end
			else if (tog_armed_q && !mode_ctrl_in)
			begin
				tog_cnt_q <= tog_cnt_q + 12'h1;
				if (!tx_data_in)
					tog_tx_seen_q <= 1'b1;
			end
			if (en_rise && tog_armed_q)
			begin
				tog_armed_q <= 1'b0;
				// Valid pulse: TX low seen and back high before EN rose
				if (tog_tx_seen_q && tx_data_in && tog_cnt_q <= 12'(`LPMTC_TOGGLE_CYC))
				begin
					fast_q <= !fast_q; // Second toggle returns to the variant's normal or slow rate
					conf_cnt_q <= 8'(`LPMTC_CONFIRM_CYC);
				end
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			bus_drive_dom_out <= 1'b0;
			rx_data_out <= 1'b1;
			regulator_switch_output <= 1'b0;
			rate_out <= SLOW_VARIANT ? LPMTC_RATE_SLOWV : LPMTC_RATE_NORM;
		end
		else
		begin
			// Driver gated by mode, validation, timeout, supply and temperature
			bus_drive_dom_out <= mode_q == LPMTC_NORMAL && tx_valid_q && !tx_timeout_q
				&& !supply_pin_low_in && !over_temp_in && !tx_data_in;
			if (over_temp_in || mode_q != LPMTC_NORMAL)
				rx_data_out <= 1'b1;
			else if (conf_cnt_q != 8'h0)
				rx_data_out <= 1'b0;
			else
				rx_data_out <= bus_level_in;
			regulator_switch_output <= !over_temp_in && mode_q != LPMTC_SLEEP;
			if (fast_q)
				rate_out <= LPMTC_RATE_FASTM;
			else
				rate_out <= SLOW_VARIANT ? LPMTC_RATE_SLOWV : LPMTC_RATE_NORM;
		end
	end
	assign mode_out = mode_q;

	// ****************************************
	// Assertions
	// ****************************************
	sequence en_drop_s;
		mode_q == LPMTC_NORMAL && en_fall;
	endsequence
	sequence stays_low_s;
		!mode_ctrl_in [*8];
	endsequence
	uv_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
		supply_pin_low_in |=> !bus_drive_dom_out) else $error("driver active under undervoltage");
	inactive_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_q != LPMTC_NORMAL |=> !bus_drive_dom_out && rx_data_out) else $error("bus active off Normal");
	overtemp_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
		over_temp_in |=> !regulator_switch_output && !bus_drive_dom_out) else $error("overtemp not handled");
	en_wake_a: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_q == LPMTC_SLEEP && en_rise && !over_temp_in ##1 !over_temp_in |=> regulator_switch_output)
		else $error("regulator not on after mode rise");
	sleep_entry_a: assert property (@(posedge clk_in) disable iff (rst_in)
		en_drop_s ##1 stays_low_s |-> mode_q == LPMTC_GO_SLEEP) else $error("sleep entered too early");
	tx_timeout_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(tx_timeout_q) |-> $past(!tx_data_in) && txdom_cnt_q == 22'(TXDOM_CYC - 1))
		else $error("timeout early");
	confirm_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(conf_cnt_q != 8'h0) && mode_q == LPMTC_NORMAL && !over_temp_in ##1 mode_q == LPMTC_NORMAL
		&& !over_temp_in |-> !rx_data_out) else $error("no fast rate confirmation");
	rx_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_q == LPMTC_NORMAL && !over_temp_in && conf_cnt_q == 8'h0 |=> rx_data_out == $past(bus_level_in))
		else $error("receive does not follow bus");
	first_valid_a: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_q == LPMTC_NORMAL && first_cnt_q == 21'(FIRSTDOM_CYC - 1) |=> tx_valid_q || mode_q != LPMTC_NORMAL)
		else $error("first dominant not validated");
endmodule
`default_nettype wire

// *** tb/lpmtc_bus_model.sv ***
/*
 Far-side model: the shared single wire with its pull-up and one other node.
 Assumes both drivers are plain levels, high meaning "pull dominant".
*/
`timescale 1ns/100ps
`default_nettype none
module lpmtc_bus_model (
	input wire logic drive_dom_in,
	input wire logic node_dom_in,
	output logic bus_level_out
);
	// Wired-AND: a released wire rests recessive through the pull-up
	assign bus_level_out = ~(drive_dom_in | node_dom_in);
endmodule
`default_nettype wire

// *** tb/lpmtc_top_tb_top.sv ***
/*
 Self-checking bench for the channel mode and timing control.
 Assumes shortened timeout parameters and a 20 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module lpmtc_top_tb_top;
	import lpmtc_pkg::*;
	logic clk_in, rst_in, tx, mode_ctrl, wake, uv, ot, node_dom, bus_level;
	logic drv, rx, regsw;
	lpmtc_mode_type mode;
	lpmtc_rate_type rate;
	lpmtc_rate_type rate_slow;
	int err_total, cmp_count;
	// Rows: tx, undervoltage, other node dominant, expected drive, expected rx
	logic [4:0] rows [6] = '{5'b10001, 5'b00010, 5'b10100, 5'b01001, 5'b01100, 5'b00010};

	lpmtc_top #(.TXDOM_CYC(50), .FIRSTDOM_CYC(100), .SLOW_VARIANT(1'b0)) i_dut (
		.clk_in(clk_in), .rst_in(rst_in), .tx_data_in(tx), .mode_ctrl_in(mode_ctrl),
		.wake_in(wake), .bus_level_in(bus_level), .supply_pin_low_in(uv),
		.over_temp_in(ot), .bus_drive_dom_out(drv), .rx_data_out(rx),
		.regulator_switch_output(regsw), .mode_out(mode), .rate_out(rate));
	// Slow variant listens on the same wire; only its rate is compared
	lpmtc_top #(.TXDOM_CYC(50), .FIRSTDOM_CYC(100), .SLOW_VARIANT(1'b1)) i_dut_slow (
		.clk_in(clk_in), .rst_in(rst_in), .tx_data_in(tx), .mode_ctrl_in(mode_ctrl),
		.wake_in(wake), .bus_level_in(bus_level), .supply_pin_low_in(uv),
		.over_temp_in(ot), .bus_drive_dom_out(), .rx_data_out(),
		.regulator_switch_output(), .mode_out(), .rate_out(rate_slow));
	lpmtc_bus_model i_bus (.drive_dom_in(drv), .node_dom_in(node_dom),
		.bus_level_out(bus_level));

	// Clock
	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int n);
		cmp_count++;
		if (n < lo || n > hi)
		begin
			err_total++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask

	// Bounded wait, so a stuck regulator switch cannot hang the run
	task automatic wait_reg(input logic val, input int lo, input int hi);
		int n;
		n = 0;
		while (regsw !== val && n <= hi)
		begin
			cyc(1);
			n++;
		end
		chk_rng("regulator delay", lo, hi, n);
	endtask

	// Host toggle; gap sets the mode low time after TX returns high, lo..hi the expected confirm length
	task automatic toggle(input lpmtc_rate_type exp, input int gap, input int lo, input int hi);
		int n;
		int w;
		n = 0;
		w = 0;
		mode_ctrl = 1'b0;
		cyc(300);
		tx = 1'b0;
		cyc(300);
		tx = 1'b1;
		cyc(gap);
		mode_ctrl = 1'b1;
		while (rx !== 1'b0 && w < 10)
		begin
			cyc(1);
			w++;
		end
		while (rx === 1'b0 && n < 200)
		begin
			cyc(1);
			n++;
		end
		chk_rng("confirm pulse", lo, hi, n);
		chk("rate", exp, rate);
	endtask

	task automatic test_done;
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog, several times the expected run length
	initial
	begin
		cyc(20000);
		err_total++;
		$display("watchdog expired");
		test_done;
	end

	// Main sequence
	initial
	begin
		err_total = 0;
		cmp_count = 0;
		rst_in = 1'b1;
		{tx, mode_ctrl, wake, uv, ot, node_dom} = 6'h20;
		cyc(2);
		rst_in = 1'b0;
		chk("drive", 2'h0, {1'b0, drv});
		chk("rx", 2'h1, {1'b0, rx});
		chk("regulator", 2'h0, {1'b0, regsw});
		chk("mode", LPMTC_SLEEP, mode);
		chk("rate", LPMTC_RATE_NORM, rate);
		chk("rate slow", LPMTC_RATE_SLOWV, rate_slow);
		$display("test reset done");
		tx = 1'b0;
		mode_ctrl = 1'b1;
		wait_reg(1'b1, 1, 300);
		chk("mode", LPMTC_NORMAL, mode);
		// Hold dominant past the validation limit; the timeout keeps the driver off
		cyc(105);
		chk("drive", 2'h0, {1'b0, drv});
		tx = 1'b1;
		cyc(2);
		for (int i = 0; i < 6; i++)
		begin
			{tx, uv, node_dom} = rows[i][4:2];
			cyc(3);
			chk("drive", {1'b0, rows[i][1]}, {1'b0, drv});
			chk("rx", {1'b0, rows[i][0]}, {1'b0, rx});
		end
		{tx, uv, node_dom} = 3'h4;
		cyc(2);
		$display("test table done");
		// Stuck-dominant transmit must be cut, but not too early
		tx = 1'b0;
		cyc(45);
		chk("drive", 2'h1, {1'b0, drv});
		cyc(15);
		chk("drive", 2'h0, {1'b0, drv});
		chk("rx", 2'h1, {1'b0, rx});
		tx = 1'b1;
		cyc(2);
		$display("test timeout done");
		toggle(LPMTC_RATE_FASTM, 250, 38, 125);
		chk("rate slow", LPMTC_RATE_FASTM, rate_slow);
		toggle(LPMTC_RATE_NORM, 250, 38, 125);
		// Mode low for 950 cycles, beyond the pulse limit: no rate change, no confirm
		toggle(LPMTC_RATE_NORM, 350, 0, 0);
		chk("rate slow", LPMTC_RATE_SLOWV, rate_slow);
		$display("test toggle done");
		mode_ctrl = 1'b0;
		wait_reg(1'b0, 1000, 1820);
		chk("mode", LPMTC_SLEEP, mode);
		tx = 1'b0;
		cyc(5);
		chk("drive", 2'h0, {1'b0, drv});
		tx = 1'b1;
		node_dom = 1'b1;
		wait_reg(1'b1, 800, 2010);
		node_dom = 1'b0;
		chk("mode", LPMTC_NORMAL, mode);
		mode_ctrl = 1'b1;
		cyc(5);
		mode_ctrl = 1'b0;
		wait_reg(1'b0, 1000, 1820);
		wake = 1'b1;
		wait_reg(1'b1, 200, 1410);
		chk("mode", LPMTC_NORMAL, mode);
		$display("test sleep and wake done");
		mode_ctrl = 1'b1;
		cyc(5);
		tx = 1'b0;
		ot = 1'b1;
		cyc(5);
		chk("drive", 2'h0, {1'b0, drv});
		chk("rx", 2'h1, {1'b0, rx});
		chk("regulator", 2'h0, {1'b0, regsw});
		$display("test overtemp done");
		test_done;
	end
endmodule
`default_nettype wire
